// >>> logic/status_reg_pkg.sv
// Constants shared by the serial status register block
package status_reg_pkg;
  localparam logic [7:0] OPC_STATUS_READ = 8'hD7;
  localparam int         BYTE_BITS       = 8;
  localparam logic [2:0] BIT_CNT_RESET   = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST    = 3'h7;
  // Second status byte field positions
  localparam int B2_READY      = 7;
  localparam int B2_SPARE_HI   = 6;
  localparam int B2_EP_FAIL    = 5;
  localparam int B2_SPARE_LO   = 4;
  localparam int B2_LOCKDOWN   = 3;
  localparam int B2_PS_SECOND  = 2;
  localparam int B2_PS_FIRST   = 1;
  localparam int B2_ERASE_SUSP = 0;
  // First status byte field positions
  localparam int B1_READY      = 7;
  localparam int B1_COMPARE    = 6;
  localparam int B1_DENS_HI    = 5;
  localparam int B1_DENS_LO    = 2;
  localparam int B1_PROTECT    = 1;
  localparam int B1_PAGE_512   = 0;
  // Values after reset
  localparam logic RST_COMPARE  = 1'b0;
  localparam logic RST_EP_FAIL  = 1'b0;
  localparam logic RST_SO       = 1'b0;
  localparam logic RST_SO_OE    = 1'b0;
  localparam logic [7:0] RST_SHIFT = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_OPCODE = 4'b0010,
    ST_STATUS = 4'b0100,
    ST_IGNORE = 4'b1000
  } link_state_t;
endpackage

// >>> logic/pin_sync.sv
// Two-stage synchroniser with edge pulses for the serial pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  output var  logic o_cs_n,
  output var  logic o_si,
  output var  logic o_sck_rise,
  output var  logic o_sck_fall
);
  logic [2:0] meta;
  logic [2:0] sync;
  logic       sck_prev;
  logic [2:0] next_meta;
  logic [2:0] next_sync;
  logic       next_sck_prev;

  always_comb
  begin
    next_meta     = {i_cs_n, i_sck, i_si};
    next_sync     = meta;
    next_sck_prev = sync[1];
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      meta     <= 3'b100;
      sync     <= 3'b100;
      sck_prev <= 1'b0;
    end
    else
    begin
      meta     <= next_meta;
      sync     <= next_sync;
      sck_prev <= next_sck_prev;
    end
  end

  always_comb
  begin
    o_cs_n     = sync[2];
    o_si       = sync[0];
    o_sck_rise = sync[1] & ~sck_prev;
    o_sck_fall = ~sync[1] & sck_prev;
  end
endmodule
`default_nettype wire

// >>> logic/serial_flash_status_register.sv
// Two-byte read-only status register with serial status-read port
//
// Operation
// - Second byte bit 7 is 0 while busy, 1 when ready.
// - Second byte bits 6 and 4 always read 0.
// - Failure flag set when a byte failed erase or program.
// - Aborted erase or program never sets the failure flag.
// - Failure flag refreshed at every erase or program end.
// - Second byte bit 3 is 1 while sector lockdown stays usable.
// - Second byte bit 2 shows program suspended using second buffer.
// - Second-buffer writes ignored while its suspend flag is set.
// - Second byte bit 1 shows program suspended using first buffer.
// - First-buffer writes ignored while its suspend flag is set.
// - Second byte bit 0 shows any erase scope suspended.
// - Compare flag is 1 when latest compare found a difference.
// - Four-bit density field is a fixed legacy code.
// - Protection flag shows sector protection enabled by any method.
// - Page-size flag is 1 for 512-byte pages, 0 for 528.
// - Opcode D7h starts status bytes one, two, repeating while selected.
// - First byte: ready, compare, density 5:2, protect, page size.
// - Ready is re-sampled for every byte shifted out.
// - Deselect ends the read at any point and floats the output.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_status_register
#(
  parameter logic [3:0] DENSITY_CODE = 4'h5  // Arbitrary value
)
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  output var  logic o_so,
  output var  logic o_so_oe,
  input  wire logic i_busy,
  input  wire logic i_compare_done,
  input  wire logic i_compare_mismatch,
  input  wire logic i_ep_done,
  input  wire logic i_ep_fail,
  input  wire logic i_ep_aborted,
  input  wire logic i_lockdown_allowed,
  input  wire logic i_prog_suspend_first,
  input  wire logic i_prog_suspend_second,
  input  wire logic i_erase_suspended,
  input  wire logic i_protect_enabled,
  input  wire logic i_page_512,
  input  wire logic i_buf1_write_req,
  input  wire logic i_buf2_write_req,
  output var  logic o_buf1_write_grant,
  output var  logic o_buf2_write_grant,
  output var  logic [7:0] o_status_second_byte
);
  logic                       cs_n;
  logic                       si;
  logic                       sck_rise;
  logic                       sck_fall;

  pin_sync u_pin_sync
  (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_cs_n     (i_cs_n),
    .i_sck      (i_sck),
    .i_si       (i_si),
    .o_cs_n     (cs_n),
    .o_si       (si),
    .o_sck_rise (sck_rise),
    .o_sck_fall (sck_fall)
  );

  // Status flag state
  logic       compare_flag;
  logic       erase_program_fail_flag;
  logic       lockdown_allowed_flag;
  logic       prog_suspend_first_buffer;
  logic       prog_suspend_second_buffer;
  logic       erase_suspended_flag;
  logic       ready;
  logic       protect_flag;
  logic       page_512_flag;
  logic       next_compare_flag;
  logic       next_erase_program_fail_flag;
  logic       next_buf1_grant;
  logic       next_buf2_grant;
  logic [7:0] first_byte;
  logic [7:0] status_second_byte;

  always_comb
  begin
    next_compare_flag = compare_flag;
    if (i_compare_done)
    begin
      next_compare_flag = i_compare_mismatch;
    end
    next_erase_program_fail_flag = erase_program_fail_flag;
    if (i_ep_done)
    begin
      next_erase_program_fail_flag = i_ep_fail & ~i_ep_aborted;
    end
    next_buf1_grant = i_buf1_write_req & ~prog_suspend_first_buffer;
    next_buf2_grant = i_buf2_write_req & ~prog_suspend_second_buffer;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      compare_flag               <= status_reg_pkg::RST_COMPARE;
      erase_program_fail_flag    <= status_reg_pkg::RST_EP_FAIL;
      lockdown_allowed_flag      <= 1'b0;
      prog_suspend_first_buffer  <= 1'b0;
      prog_suspend_second_buffer <= 1'b0;
      erase_suspended_flag       <= 1'b0;
      ready                      <= 1'b0;
      protect_flag               <= 1'b0;
      page_512_flag              <= 1'b0;
      o_buf1_write_grant         <= 1'b0;
      o_buf2_write_grant         <= 1'b0;
      o_status_second_byte       <= 8'h00;
    end
    else
    begin
      compare_flag               <= next_compare_flag;
      erase_program_fail_flag    <= next_erase_program_fail_flag;
      lockdown_allowed_flag      <= i_lockdown_allowed;
      prog_suspend_first_buffer  <= i_prog_suspend_first;
      prog_suspend_second_buffer <= i_prog_suspend_second;
      erase_suspended_flag       <= i_erase_suspended;
      ready                      <= ~i_busy;
      protect_flag               <= i_protect_enabled;
      page_512_flag              <= i_page_512;
      o_buf1_write_grant         <= next_buf1_grant;
      o_buf2_write_grant         <= next_buf2_grant;
      o_status_second_byte       <= status_second_byte;
    end
  end

  always_comb
  begin
    status_second_byte = 8'h00;
    status_second_byte[status_reg_pkg::B2_READY]      = ready;
    status_second_byte[status_reg_pkg::B2_SPARE_HI]   = 1'b0;
    status_second_byte[status_reg_pkg::B2_EP_FAIL]    = erase_program_fail_flag;
    status_second_byte[status_reg_pkg::B2_SPARE_LO]   = 1'b0;
    status_second_byte[status_reg_pkg::B2_LOCKDOWN]   = lockdown_allowed_flag;
    status_second_byte[status_reg_pkg::B2_PS_SECOND]  = prog_suspend_second_buffer;
    status_second_byte[status_reg_pkg::B2_PS_FIRST]   = prog_suspend_first_buffer;
    status_second_byte[status_reg_pkg::B2_ERASE_SUSP] = erase_suspended_flag;
    first_byte = 8'h00;
    first_byte[status_reg_pkg::B1_READY]    = ready;
    first_byte[status_reg_pkg::B1_COMPARE]  = compare_flag;
    first_byte[status_reg_pkg::B1_DENS_HI:status_reg_pkg::B1_DENS_LO] = DENSITY_CODE;
    first_byte[status_reg_pkg::B1_PROTECT]  = protect_flag;
    first_byte[status_reg_pkg::B1_PAGE_512] = page_512_flag;
  end

  // Serial link state
  status_reg_pkg::link_state_t state;
  status_reg_pkg::link_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic       byte_sel;
  logic       next_byte_sel;
  logic       next_so;
  logic       next_so_oe;
  logic [7:0] load_byte;

  always_comb
  begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_byte_sel = byte_sel;
    next_so       = o_so;
    next_so_oe    = o_so_oe;
    // Ready taken fresh at each byte load
    load_byte     = byte_sel ? status_second_byte : first_byte;
    if (cs_n)
    begin
      next_state   = status_reg_pkg::ST_IDLE;
      next_so_oe   = 1'b0;
      next_bit_cnt = status_reg_pkg::BIT_CNT_RESET;
    end
    else
    begin
      case (state)
        status_reg_pkg::ST_IDLE:
        begin
          next_state   = status_reg_pkg::ST_OPCODE;
          next_bit_cnt = status_reg_pkg::BIT_CNT_RESET;
        end
        status_reg_pkg::ST_OPCODE:
        begin
          if (sck_rise)
          begin
            next_shift   = {shift[6:0], si};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == status_reg_pkg::BIT_CNT_LAST)
            begin
              next_byte_sel = 1'b0;
              if ({shift[6:0], si} == status_reg_pkg::OPC_STATUS_READ)
              begin
                next_state = status_reg_pkg::ST_STATUS;
              end
              else
              begin
                next_state = status_reg_pkg::ST_IGNORE;
              end
            end
          end
        end
        status_reg_pkg::ST_STATUS:
        begin
          next_so_oe = 1'b1;
          if (sck_rise)
          begin
            next_bit_cnt = bit_cnt + 3'h1;
          end
          if (sck_fall)
          begin
            if (bit_cnt == status_reg_pkg::BIT_CNT_RESET)
            begin
              next_so       = load_byte[7];
              next_shift    = {load_byte[6:0], 1'b0};
              next_byte_sel = ~byte_sel;
            end
            else
            begin
              next_so    = shift[7];
              next_shift = {shift[6:0], 1'b0};
            end
          end
        end
        status_reg_pkg::ST_IGNORE:
        begin
          next_so_oe = 1'b0;
        end
        default:
        begin
          next_state = status_reg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state    <= status_reg_pkg::ST_IDLE;
      bit_cnt  <= status_reg_pkg::BIT_CNT_RESET;
      shift    <= status_reg_pkg::RST_SHIFT;
      byte_sel <= 1'b0;
      o_so     <= status_reg_pkg::RST_SO;
      o_so_oe  <= status_reg_pkg::RST_SO_OE;
    end
    else
    begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
      byte_sel <= next_byte_sel;
      o_so     <= next_so;
      o_so_oe  <= next_so_oe;
    end
  end
endmodule
`default_nettype wire

// >>> bench/spi_host_model.sv
// Serial host model that selects the port and shifts status out
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
  input  wire logic i_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output var  logic o_cs_n,
  output var  logic o_sck,
  output var  logic o_si
);
  logic tog = 1'b0;
  logic so_line;
  // Floating line shows a changing pattern
  assign so_line = i_so_oe ? i_so : tog;
  always @(posedge i_clk) tog <= ~tog;
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  task automatic xfer(input logic [7:0] opc, input int n, output logic [31:0] rd);
    rd = 32'h0000_0000;
    o_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      o_si = opc[i];
      half();
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
    end
    for (int i = 0; i < n; i++)
    begin
      half();
      rd = {rd[30:0], so_line};
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
    end
    half();
    o_cs_n = 1'b1;
    o_si = ~o_si;
    repeat (6) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// >>> bench/status_reg_chk.sv
// Checker on the status register block ports
`timescale 1ns/10ps
`default_nettype none
module status_reg_chk
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cs_n,
  input  wire logic       o_so_oe,
  input  wire logic       i_busy,
  input  wire logic       i_ep_done,
  input  wire logic       i_ep_fail,
  input  wire logic       i_ep_aborted,
  input  wire logic       i_lockdown_allowed,
  input  wire logic       i_prog_suspend_first,
  input  wire logic       i_prog_suspend_second,
  input  wire logic       i_buf1_write_req,
  input  wire logic       i_buf2_write_req,
  input  wire logic       o_buf1_write_grant,
  input  wire logic       o_buf2_write_grant,
  input  wire logic [7:0] o_status_second_byte
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_oe_desel: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("output enabled while deselected");
  a_spare_zero: assert property (!o_status_second_byte[6] && !o_status_second_byte[4])
    else $error("spare bit set");
  a_ready_high: assert property ((!i_busy) [*3] |-> o_status_second_byte[7])
    else $error("ready bit low while idle");
  a_busy_low: assert property (i_busy [*3] |-> !o_status_second_byte[7])
    else $error("ready bit high while busy");
  a_lock_bit: assert property (i_lockdown_allowed [*3] |-> o_status_second_byte[3])
    else $error("lockdown bit low");
  a_ps_second: assert property ((!i_prog_suspend_second) [*3] |-> !o_status_second_byte[2])
    else $error("second buffer suspend bit set");
  a_ep_fail: assert property (i_ep_done && i_ep_fail && !i_ep_aborted |-> ##[1:3] o_status_second_byte[5])
    else $error("failure flag not set");
  a_ep_abort: assert property (i_ep_done && i_ep_aborted |-> ##[1:3] !o_status_second_byte[5])
    else $error("failure flag set on abort");
  // Grant uses the registered suspend flag, so suspend input counts two cycles back
  a_grant_first: assert property (o_buf1_write_grant |-> $past(i_buf1_write_req) &&
    !($past(i_prog_suspend_first, 2) && !$past(i_rst, 2)))
    else $error("first buffer written while suspended");
  a_grant_second: assert property ($past(i_buf2_write_req) &&
    !$past(i_prog_suspend_second, 2) && !$past(i_rst) |-> o_buf2_write_grant)
    else $error("second buffer grant missing");
endmodule
bind serial_flash_status_register status_reg_chk u_status_reg_chk (.i_sys_clk, .i_rst, .i_cs_n,
  .o_so_oe, .i_busy, .i_ep_done, .i_ep_fail, .i_ep_aborted, .i_lockdown_allowed,
  .i_prog_suspend_first, .i_prog_suspend_second, .i_buf1_write_req, .i_buf2_write_req,
  .o_buf1_write_grant, .o_buf2_write_grant, .o_status_second_byte);
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the serial status register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [3:0] DENS = 4'h5;
  logic clk = 1'b0, rst = 1'b1, busy = 1'b0, cdone = 1'b0, cmis = 1'b0, edone = 1'b0;
  logic efail = 1'b0, eabort = 1'b0, lock = 1'b0, ps1 = 1'b0, ps2 = 1'b0, es = 1'b0;
  logic prot = 1'b0, p512 = 1'b0, req1 = 1'b0, req2 = 1'b0, cmp_f = 1'b0, ep_f = 1'b0;
  logic cs_n, sck, si, so, so_oe, g1, g2;
  logic [7:0] sb2;
  int checked = 0, miscompares = 0, cycles = 0, oe_hits = 0;
  always #5 clk = ~clk;
  serial_flash_status_register #(.DENSITY_CODE(DENS)) u_serial_flash_status_register (
    .i_sys_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .i_busy(busy), .i_compare_done(cdone), .i_compare_mismatch(cmis),
    .i_ep_done(edone), .i_ep_fail(efail), .i_ep_aborted(eabort), .i_lockdown_allowed(lock),
    .i_prog_suspend_first(ps1), .i_prog_suspend_second(ps2), .i_erase_suspended(es),
    .i_protect_enabled(prot), .i_page_512(p512), .i_buf1_write_req(req1),
    .i_buf2_write_req(req2), .o_buf1_write_grant(g1), .o_buf2_write_grant(g2),
    .o_status_second_byte(sb2));
  spi_host_model u_spi_host_model (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si));
  always @(posedge clk)
  begin
    cycles++;
    if (so_oe === 1'b1)
      oe_hits++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] exp_st(input logic rdy);
    return {rdy, cmp_f, DENS, prot, p512, rdy, 1'b0, ep_f, 1'b0, lock, ps2, ps1, es};
  endfunction
  task automatic read_check();
    logic [31:0] rd;
    u_spi_host_model.xfer(8'hD7, 16, rd);
    check("status bytes", rd, exp_st(1'b1));
    check("second byte", sb2, exp_st(1'b1) & 16'h00FF);
  endtask
  task automatic pulse(input logic c, input logic e);
    cdone = c;
    edone = e;
    @(negedge clk);
    cdone = 1'b0;
    edone = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_fields();
    for (int i = 0; i < 2; i++)
    begin
      {lock, ps2, ps1, es, prot, p512} = i ? 6'h15 : 6'h2A;
      repeat (4) @(negedge clk);
      read_check();
    end
    $display("test fields done");
  endtask
  task automatic t_events();
    cmis = 1'b1;
    efail = 1'b1;
    pulse(1'b1, 1'b1);
    cmis = 1'b0;
    cmp_f = 1'b1;
    ep_f = 1'b1;
    read_check();
    eabort = 1'b1;
    pulse(1'b0, 1'b1);
    ep_f = 1'b0;
    read_check();
    eabort = 1'b0;
    pulse(1'b0, 1'b1);
    ep_f = 1'b1;
    read_check();
    efail = 1'b0;
    pulse(1'b1, 1'b1);
    cmp_f = 1'b0;
    ep_f = 1'b0;
    read_check();
    $display("test events done");
  endtask
  task automatic t_busy();
    logic [31:0] rd;
    busy = 1'b1;
    fork
      u_spi_host_model.xfer(8'hD7, 24, rd);
      begin
        repeat (160) @(negedge clk);
        busy = 1'b0;
      end
    join
    check("ready per byte", {rd[23], rd[15], rd[7]}, 3'h1);
    $display("test busy done");
  endtask
  task automatic t_edges();
    logic [31:0] rd;
    int n;
    u_spi_host_model.xfer(8'hD7, 5, rd);
    check("oe after deselect", so_oe, 1'b0);
    n = oe_hits;
    u_spi_host_model.xfer(8'h9F, 8, rd);
    check("oe other opcode", oe_hits, n);
    $display("test edges done");
  endtask
  task automatic t_grant();
    for (int i = 0; i < 5; i++)
    begin
      {ps1, ps2} = i[1:0];
      req1 = (i < 4);
      req2 = (i < 4);
      repeat (3) @(negedge clk);
      check("grant first", g1, req1 & ~ps1);
      check("grant second", g2, req2 & ~ps2);
    end
    $display("test grant done");
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_fields();
    t_events();
    t_busy();
    t_edges();
    t_grant();
    end_sim();
  end
endmodule
`default_nettype wire
